// *** design/ntla_pkg.sv ***
package ntla_pkg;

  // Line signal codes received from the exchange side
  typedef enum logic [3:0] {
    RX_NONE = 4'h0,
    RX_SIG0 = 4'h1,
    RX_SIG2W = 4'h2,
    RX_SIG2 = 4'h3,
    RX_SIG4H = 4'h4,
    RX_SIG4 = 4'h5,
    RX_SIG2_L2 = 4'h6,
    RX_SIG4H_L2 = 4'h7,
    RX_SIG4_L2 = 4'h8
  } ntla_rx_sig_t;

  // Line signal codes sent toward the exchange side
  typedef enum logic [2:0] {
    TX_SIG0 = 3'h0,
    TX_SIG1W = 3'h1,
    TX_SIG1A = 3'h2,
    TX_SIG1 = 3'h3,
    TX_SIG3 = 3'h4,
    TX_SIG5 = 3'h5
  } ntla_tx_sig_t;

  // User side INFO codes; UZERO is the unframed all-zero signal
  typedef enum logic [2:0] {
    INFO0 = 3'h0,
    INFO1 = 3'h1,
    INFO2 = 3'h2,
    INFO3 = 3'h3,
    INFO4 = 3'h4,
    UZERO = 3'h5
  } ntla_info_t;

  // One-hot activation states
  typedef enum logic [11:0] {
    ST_DEACT = 12'h001,
    ST_LWAKE = 12'h002,
    ST_RWAKE = 12'h004,
    ST_WSYNC = 12'h008,
    ST_NSYNC = 12'h010,
    ST_BSYNC = 12'h020,
    ST_FULL = 12'h040,
    ST_PDEACT = 12'h080,
    ST_UFAULT = 12'h100,
    ST_LFAULT = 12'h200,
    ST_LBPEND = 12'h400,
    ST_LBACT = 12'h800
  } ntla_state_t;

  // Received events, each a one-cycle strobe
  typedef struct packed {
    ntla_rx_sig_t sig;
    logic sig_vld;
    ntla_info_t info;
    logic info_vld;
    logic line_frame_lost;
    logic user_frame_lost;
  } ntla_rx_t;

  // Transmit directives
  typedef struct packed {
    ntla_tx_sig_t line_sig;
    ntla_info_t user_info;
    logic d_echo_zero;
    logic loopback;
    logic bd_enable;
  } ntla_tx_t;

  localparam int CLK_HZ = 25000000;
  localparam int WAKE_REPEAT_MS = 13;
  localparam int WAKE_REPEAT_CYC = CLK_HZ / 1000 * WAKE_REPEAT_MS;
  localparam int DEACT_DEFAULT_MS = 100;
  localparam int DEACT_DEFAULT_CYC = CLK_HZ / 1000 * DEACT_DEFAULT_MS;
  localparam int TMR_W = 32;
  localparam ntla_state_t RESET_STATE = ST_DEACT;

endpackage

// *** design/ntla_fsm.sv ***
`timescale 1ns/1ps
// Operation
// - After reset, deactivated: send nothing, leave only on wake request.
// - INFO 1 when deactivated: go local wake, send SIG 1W.
// - Local wake: SIG 2W acknowledges, go wait for synchronisation.
// - SIG 2W when deactivated: start wake timer, remote wake, send SIG 1W.
// - Wake timer expiry in remote wake: send SIG 1A, wait for sync.
// - Further SIG 2W in remote wake restarts the wake timer.
// - Waiting for sync: SIG 2 moves to network-synchronised.
// - Network-synchronised: send SIG 1 to line, INFO 2 to user.
// - Network-synchronised: INFO 3 moves to both-ways-synchronised.
// - Both-ways: send SIG 3 and INFO 2; SIG 4H gives full activation.
// - Full activation: send INFO 4 and SIG 5, channels carried.
// - SIG 0 from wait-sync onward: start deactivation timer, pend.
// - Pending deactivation ends on INFO 0 or deactivation timer expiry.
// - User INFO 0 or lost framing in full: user fault until INFO 3.
// - Line framing lost from network-sync onward: line fault state.
// - Line fault sends the unframed all-zero signal to user.
// - Line fault may send any error-causing line signal; SIG 0 used.
// - Active loopback sends INFO 4 with D-echo bit zero.
// - Loopback entry on SIG 4H-L2 or SIG 4-L2; B and D returned.
// - Impossible pairs undefined; no-change pairs keep the state.
// - Wake-repeat timer lasts 13 ms.
// - Loopback pending sends SIG 3 and INFO 2, waits SIG 4H-L2.
module ntla_fsm #(
  parameter int DEACT_CYC = ntla_pkg::DEACT_DEFAULT_CYC,
  parameter int WAKE_CYC = ntla_pkg::WAKE_REPEAT_CYC
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // Received events
  input wire ntla_pkg::ntla_rx_t RX_EVT,
  // Transmit directives and state
  output ntla_pkg::ntla_tx_t TX_OUT,
  output ntla_pkg::ntla_state_t STATE
);

  ntla_pkg::ntla_state_t state_ff, nxt_state;
  logic [ntla_pkg::TMR_W-1:0] wake_tmr_ff, nxt_wake_tmr;
  logic [ntla_pkg::TMR_W-1:0] deact_tmr_ff, nxt_deact_tmr;
  ntla_pkg::ntla_tx_t tx_ff, nxt_tx;
  logic s0, s2w, s2, s4h, s4, s2l2, s4hl2, s4l2;
  logic i0, i1, i3, wake_exp, deact_exp;

  // Event decode; events arrive on this clock, no synchroniser needed
  always_comb begin
    s0 = RX_EVT.sig_vld && RX_EVT.sig == ntla_pkg::RX_SIG0;
    s2w = RX_EVT.sig_vld && RX_EVT.sig == ntla_pkg::RX_SIG2W;
    s2 = RX_EVT.sig_vld && RX_EVT.sig == ntla_pkg::RX_SIG2;
    s4h = RX_EVT.sig_vld && RX_EVT.sig == ntla_pkg::RX_SIG4H;
    s4 = RX_EVT.sig_vld && RX_EVT.sig == ntla_pkg::RX_SIG4;
    s2l2 = RX_EVT.sig_vld && RX_EVT.sig == ntla_pkg::RX_SIG2_L2;
    s4hl2 = RX_EVT.sig_vld && RX_EVT.sig == ntla_pkg::RX_SIG4H_L2;
    s4l2 = RX_EVT.sig_vld && RX_EVT.sig == ntla_pkg::RX_SIG4_L2;
    i0 = RX_EVT.info_vld && RX_EVT.info == ntla_pkg::INFO0;
    i1 = RX_EVT.info_vld && RX_EVT.info == ntla_pkg::INFO1;
    i3 = RX_EVT.info_vld && RX_EVT.info == ntla_pkg::INFO3;
    wake_exp = wake_tmr_ff == ntla_pkg::TMR_W'(1);
    deact_exp = deact_tmr_ff == ntla_pkg::TMR_W'(1);
  end

  // Next state; line-side events take priority over user-side ones
  always_comb begin
    nxt_state = state_ff;
    nxt_wake_tmr = (wake_tmr_ff != '0) ? wake_tmr_ff - 1'b1 : wake_tmr_ff;
    nxt_deact_tmr = (deact_tmr_ff != '0) ? deact_tmr_ff - 1'b1 : deact_tmr_ff;
    case (state_ff)
      ntla_pkg::ST_DEACT: begin
        if (s2w) begin
          nxt_state = ntla_pkg::ST_RWAKE;
          nxt_wake_tmr = ntla_pkg::TMR_W'(WAKE_CYC);
        end else if (i1) begin
          nxt_state = ntla_pkg::ST_LWAKE;
        end
      end
      ntla_pkg::ST_LWAKE: begin
        if (s2w) nxt_state = ntla_pkg::ST_WSYNC;
      end
      ntla_pkg::ST_RWAKE: begin
        if (s2w) begin
          nxt_wake_tmr = ntla_pkg::TMR_W'(WAKE_CYC);
        end else if (wake_exp) begin
          nxt_state = ntla_pkg::ST_WSYNC;
          nxt_wake_tmr = '0;
        end
      end
      ntla_pkg::ST_WSYNC: begin
        if (s2) nxt_state = ntla_pkg::ST_NSYNC;
        else if (s2l2) nxt_state = ntla_pkg::ST_LBPEND;
      end
      ntla_pkg::ST_NSYNC: begin
        if (i3) nxt_state = ntla_pkg::ST_BSYNC;
      end
      ntla_pkg::ST_BSYNC: begin
        if (s4h) nxt_state = ntla_pkg::ST_FULL;
        else if (s4hl2) nxt_state = ntla_pkg::ST_LBACT;
      end
      ntla_pkg::ST_FULL: begin
        if (s4l2) nxt_state = ntla_pkg::ST_LBACT;
        else if (i0 || RX_EVT.user_frame_lost)
          nxt_state = ntla_pkg::ST_UFAULT;
      end
      ntla_pkg::ST_PDEACT: begin
        // first of INFO 0 or timer expiry
        if (i0 || deact_exp) begin
          nxt_state = ntla_pkg::ST_DEACT;
          nxt_deact_tmr = '0;
        end
      end
      ntla_pkg::ST_UFAULT: begin
        if (s4l2) nxt_state = ntla_pkg::ST_LBACT;
        else if (i3) nxt_state = ntla_pkg::ST_FULL;
      end
      ntla_pkg::ST_LFAULT: begin
        if (s4l2) nxt_state = ntla_pkg::ST_LBACT;
      end
      ntla_pkg::ST_LBPEND: begin
        if (s4h) nxt_state = ntla_pkg::ST_FULL;
        else if (s4hl2) nxt_state = ntla_pkg::ST_LBACT;
      end
      ntla_pkg::ST_LBACT: begin
        if (s4) nxt_state = ntla_pkg::ST_FULL;
      end
      // Illegal code recovers to reset
      default: nxt_state = ntla_pkg::RESET_STATE;
    endcase
    if (RX_EVT.line_frame_lost &&
        (state_ff & (ntla_pkg::ST_NSYNC | ntla_pkg::ST_BSYNC |
                     ntla_pkg::ST_FULL | ntla_pkg::ST_UFAULT |
                     ntla_pkg::ST_LBPEND | ntla_pkg::ST_LBACT)) != '0)
      nxt_state = ntla_pkg::ST_LFAULT;
    if (s0 && (state_ff & (ntla_pkg::ST_DEACT | ntla_pkg::ST_LWAKE |
                           ntla_pkg::ST_RWAKE | ntla_pkg::ST_PDEACT)) == '0)
    begin
      nxt_state = ntla_pkg::ST_PDEACT;
      nxt_deact_tmr = ntla_pkg::TMR_W'(DEACT_CYC);
    end
  end

  // Outputs follow the next state so they change with the state register
  always_comb begin
    nxt_tx = '0;
    nxt_tx.line_sig = ntla_pkg::TX_SIG0;
    nxt_tx.user_info = ntla_pkg::INFO0;
    case (nxt_state)
      ntla_pkg::ST_LWAKE, ntla_pkg::ST_RWAKE: begin
        nxt_tx.line_sig = ntla_pkg::TX_SIG1W;
      end
      ntla_pkg::ST_WSYNC: begin
        nxt_tx.line_sig = ntla_pkg::TX_SIG1A;
      end
      ntla_pkg::ST_NSYNC: begin
        nxt_tx.line_sig = ntla_pkg::TX_SIG1;
        nxt_tx.user_info = ntla_pkg::INFO2;
      end
      ntla_pkg::ST_BSYNC, ntla_pkg::ST_LBPEND: begin
        nxt_tx.line_sig = ntla_pkg::TX_SIG3;
        nxt_tx.user_info = ntla_pkg::INFO2;
      end
      ntla_pkg::ST_FULL: begin
        nxt_tx.line_sig = ntla_pkg::TX_SIG5;
        nxt_tx.user_info = ntla_pkg::INFO4;
        nxt_tx.bd_enable = 1'b1;
      end
      ntla_pkg::ST_UFAULT: begin
        nxt_tx.line_sig = ntla_pkg::TX_SIG5;
        nxt_tx.user_info = ntla_pkg::INFO2;
      end
      ntla_pkg::ST_LFAULT: begin
        nxt_tx.user_info = ntla_pkg::UZERO;
      end
      ntla_pkg::ST_LBACT: begin
        nxt_tx.line_sig = ntla_pkg::TX_SIG5;
        nxt_tx.user_info = ntla_pkg::INFO4;
        nxt_tx.d_echo_zero = 1'b1;
        nxt_tx.loopback = 1'b1;
        nxt_tx.bd_enable = 1'b1;
      end
      default: nxt_tx.line_sig = ntla_pkg::TX_SIG0;
    endcase
  end

  // Register stage
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      state_ff <= ntla_pkg::RESET_STATE;
      wake_tmr_ff <= '0;
      deact_tmr_ff <= '0;
      tx_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      wake_tmr_ff <= nxt_wake_tmr;
      deact_tmr_ff <= nxt_deact_tmr;
      tx_ff <= nxt_tx;
    end
  end

  assign TX_OUT = tx_ff;
  assign STATE = state_ff;

  // Cycles in remote wake since the last SIG 2W; the expiry edge counts too
  int unsigned rw_cnt;
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) rw_cnt <= 0;
    else if (state_ff == ntla_pkg::ST_RWAKE && !s2w) rw_cnt <= rw_cnt + 1;
    else rw_cnt <= 0;
  end

  idle_quiet_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_DEACT |-> tx_ff.line_sig == ntla_pkg::TX_SIG0
    && tx_ff.user_info == ntla_pkg::INFO0)
    else $error("deactivated state not silent");
  local_wake_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_DEACT && i1 && !s2w && !s0 |=>
    state_ff == ntla_pkg::ST_LWAKE && tx_ff.line_sig == ntla_pkg::TX_SIG1W)
    else $error("local wake not entered");
  wake_ack_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_LWAKE && s2w |=> state_ff == ntla_pkg::ST_WSYNC)
    else $error("wake acknowledge ignored");
  remote_wake_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_DEACT && s2w |=>
    state_ff == ntla_pkg::ST_RWAKE && wake_tmr_ff == WAKE_CYC)
    else $error("remote wake not started");
  wake_expiry_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    rw_cnt <= WAKE_CYC)
    else $error("wake timer overran");
  wake_restart_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_RWAKE && s2w && !s0 |=>
    state_ff == ntla_pkg::ST_RWAKE)
    else $error("repeat wake did not defer");
  line_sync_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_WSYNC && s2 && !s0 |=>
    state_ff == ntla_pkg::ST_NSYNC && tx_ff.user_info == ntla_pkg::INFO2)
    else $error("sync on SIG 2 missed");
  deact_start_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    s0 && state_ff == ntla_pkg::ST_FULL |=>
    state_ff == ntla_pkg::ST_PDEACT && deact_tmr_ff == DEACT_CYC)
    else $error("pending deactivation not entered");
  deact_end_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_PDEACT && i0 |=> state_ff == ntla_pkg::ST_DEACT)
    else $error("INFO 0 did not deactivate");
  line_fault_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    RX_EVT.line_frame_lost && !s0 && state_ff == ntla_pkg::ST_FULL |=>
    state_ff == ntla_pkg::ST_LFAULT && tx_ff.user_info == ntla_pkg::UZERO)
    else $error("line fault not entered");
  net_sync_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_NSYNC |->
    tx_ff.line_sig == ntla_pkg::TX_SIG1 && tx_ff.user_info == ntla_pkg::INFO2)
    else $error("network sync outputs wrong");
  two_way_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_NSYNC && i3 && !s0 && !RX_EVT.line_frame_lost
    |=> state_ff == ntla_pkg::ST_BSYNC)
    else $error("INFO 3 did not synchronise");
  go_full_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_BSYNC && s4h && !RX_EVT.line_frame_lost |=>
    state_ff == ntla_pkg::ST_FULL)
    else $error("SIG 4H did not activate");
  full_tx_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_FULL |-> tx_ff.line_sig == ntla_pkg::TX_SIG5 &&
    tx_ff.user_info == ntla_pkg::INFO4 && tx_ff.bd_enable)
    else $error("full activation outputs wrong");
  u_fault_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_FULL && (i0 || RX_EVT.user_frame_lost) &&
    !s0 && !s4l2 && !RX_EVT.line_frame_lost |=>
    state_ff == ntla_pkg::ST_UFAULT && tx_ff.user_info == ntla_pkg::INFO2)
    else $error("user fault not entered");
  zero_tx_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_LFAULT |-> tx_ff.user_info == ntla_pkg::UZERO
    && tx_ff.line_sig == ntla_pkg::TX_SIG0)
    else $error("line fault outputs wrong");
  echo_lb_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_LBACT |-> tx_ff.d_echo_zero && tx_ff.loopback &&
    tx_ff.user_info == ntla_pkg::INFO4)
    else $error("loopback echo bit not zero");
  pend_tx_a : assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_ff == ntla_pkg::ST_LBPEND |->
    tx_ff.line_sig == ntla_pkg::TX_SIG3 && tx_ff.user_info == ntla_pkg::INFO2)
    else $error("loopback pending outputs wrong");

endmodule

// *** bench/ntla_lt_model.sv ***
`timescale 1ns/1ps
module ntla_lt_model (
  // Clock
  input wire logic clk,
  // Line signal sent by the device
  input wire ntla_pkg::ntla_tx_sig_t line_sig,
  // Line events toward the device
  output ntla_pkg::ntla_rx_sig_t sig,
  output logic sig_vld,
  output logic frame_lost
);
  // Quiet line at time zero; the code is ignored while valid is low
  initial begin
    sig = ntla_pkg::RX_NONE;
    sig_vld = 1'b0;
    frame_lost = 1'b0;
  end

  // One-cycle strobe, optionally after a slow gap of idle cycles
  task automatic send(input ntla_pkg::ntla_rx_sig_t s, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    #1;
    sig = s;
    sig_vld = 1'b1;
    @(posedge clk);
    #1;
    sig = ntla_pkg::RX_NONE;
    sig_vld = 1'b0;
  endtask

  // Receiver loses line framing for one cycle
  task automatic lose();
    @(posedge clk);
    #1;
    frame_lost = 1'b1;
    @(posedge clk);
    #1;
    frame_lost = 1'b0;
  endtask

  // answer SIG 4H
  // Bounded wait for both-way sync indication, then full-activation request
  task automatic answer_sync(input int gap);
    int n;
    n = 0;
    while (line_sig !== ntla_pkg::TX_SIG3 && n < 50) begin
      // Look after the edge so the registered output has settled
      @(posedge clk);
      #1;
      n++;
    end
    send(ntla_pkg::RX_SIG4H, gap);
  endtask
endmodule

// *** bench/tb_nt_line_activation_fsm.sv ***
`timescale 1ns/1ps
module tb_nt_line_activation_fsm;
  // Short timers keep the run brief
  localparam int DEACT = 20;
  localparam int WAKE = 10;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  ntla_pkg::ntla_rx_sig_t lt_sig;
  logic lt_vld;
  logic lt_lost;
  ntla_pkg::ntla_info_t u_info = ntla_pkg::INFO0;
  logic u_vld = 1'b0;
  logic u_lost = 1'b0;
  ntla_pkg::ntla_rx_t rx_evt;
  ntla_pkg::ntla_tx_t tx_out;
  ntla_pkg::ntla_state_t state;
  int mismatches = 0;
  int compares = 0;

  always #20 ref_clk = ~ref_clk;
  assign rx_evt = {lt_sig, lt_vld, u_info, u_vld, lt_lost, u_lost};

  ntla_fsm #(.DEACT_CYC(DEACT), .WAKE_CYC(WAKE)) DUT (
    .REF_CLK(ref_clk), .RSTN(rstn), .RX_EVT(rx_evt),
    .TX_OUT(tx_out), .STATE(state));
  ntla_lt_model lt (.clk(ref_clk), .line_sig(tx_out.line_sig),
    .sig(lt_sig), .sig_vld(lt_vld), .frame_lost(lt_lost));

  task automatic conclude();
    $display("Compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Let one more edge land so registered outputs are settled
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic expect_out(input ntla_pkg::ntla_state_t s,
      input ntla_pkg::ntla_tx_sig_t l, input ntla_pkg::ntla_info_t u);
    step();
    chk(state, s);
    chk(tx_out.line_sig, l);
    chk(tx_out.user_info, u);
  endtask

  // One-cycle user INFO strobe
  task automatic uev(input ntla_pkg::ntla_info_t i);
    @(posedge ref_clk);
    #1;
    u_info = i;
    u_vld = 1'b1;
    @(posedge ref_clk);
    #1;
    u_vld = 1'b0;
  endtask

  // One-cycle loss of user-side framing
  task automatic ulose();
    @(posedge ref_clk);
    #1;
    u_lost = 1'b1;
    @(posedge ref_clk);
    #1;
    u_lost = 1'b0;
  endtask

  task automatic t_idle();
    expect_out(ntla_pkg::ST_DEACT, ntla_pkg::TX_SIG0, ntla_pkg::INFO0);
    uev(ntla_pkg::INFO0);
    expect_out(ntla_pkg::ST_DEACT, ntla_pkg::TX_SIG0, ntla_pkg::INFO0);
    lt.send(ntla_pkg::RX_SIG0, 0);
    expect_out(ntla_pkg::ST_DEACT, ntla_pkg::TX_SIG0, ntla_pkg::INFO0);
    $display("Test idle done");
  endtask

  task automatic t_remote();
    int n;
    lt.send(ntla_pkg::RX_SIG2W, 0);
    expect_out(ntla_pkg::ST_RWAKE, ntla_pkg::TX_SIG1W, ntla_pkg::INFO0);
    lt.send(ntla_pkg::RX_SIG2W, 4);
    repeat (WAKE - 3) step();
    chk(state, ntla_pkg::ST_RWAKE);
    n = 0;
    while (state !== ntla_pkg::ST_WSYNC && n < 6) begin
      step();
      n++;
    end
    chk(16'(n), 16'h0003);
    chk(tx_out.line_sig, ntla_pkg::TX_SIG1A);
    lt.send(ntla_pkg::RX_SIG2, 1);
    expect_out(ntla_pkg::ST_NSYNC, ntla_pkg::TX_SIG1, ntla_pkg::INFO2);
    uev(ntla_pkg::INFO3);
    expect_out(ntla_pkg::ST_BSYNC, ntla_pkg::TX_SIG3,
      ntla_pkg::INFO2);
    lt.answer_sync(3);
    expect_out(ntla_pkg::ST_FULL, ntla_pkg::TX_SIG5, ntla_pkg::INFO4);
    chk(tx_out.bd_enable, 1'b1);
    uev(ntla_pkg::INFO0);
    expect_out(ntla_pkg::ST_UFAULT, ntla_pkg::TX_SIG5, ntla_pkg::INFO2);
    uev(ntla_pkg::INFO3);
    expect_out(ntla_pkg::ST_FULL, ntla_pkg::TX_SIG5, ntla_pkg::INFO4);
    lt.lose();
    expect_out(ntla_pkg::ST_LFAULT, ntla_pkg::TX_SIG0, ntla_pkg::UZERO);
    lt.send(ntla_pkg::RX_SIG4_L2, 0);
    expect_out(ntla_pkg::ST_LBACT, ntla_pkg::TX_SIG5, ntla_pkg::INFO4);
    chk({tx_out.d_echo_zero, tx_out.loopback}, 2'b11);
    lt.send(ntla_pkg::RX_SIG4, 0);
    expect_out(ntla_pkg::ST_FULL, ntla_pkg::TX_SIG5, ntla_pkg::INFO4);
    lt.send(ntla_pkg::RX_SIG0, 0);
    expect_out(ntla_pkg::ST_PDEACT, ntla_pkg::TX_SIG0, ntla_pkg::INFO0);
    n = 0;
    while (state !== ntla_pkg::ST_DEACT && n < DEACT + 3) begin
      step();
      n++;
    end
    chk(n >= DEACT - 3 && state === ntla_pkg::ST_DEACT, 1'b1);
    $display("Test remote wake done");
  endtask

  task automatic t_local();
    uev(ntla_pkg::INFO1);
    expect_out(ntla_pkg::ST_LWAKE, ntla_pkg::TX_SIG1W, ntla_pkg::INFO0);
    lt.send(ntla_pkg::RX_SIG2W, 2);
    step();
    chk(state, ntla_pkg::ST_WSYNC);
    lt.send(ntla_pkg::RX_SIG2_L2, 0);
    expect_out(ntla_pkg::ST_LBPEND, ntla_pkg::TX_SIG3, ntla_pkg::INFO2);
    lt.send(ntla_pkg::RX_SIG4H_L2, 0);
    expect_out(ntla_pkg::ST_LBACT, ntla_pkg::TX_SIG5, ntla_pkg::INFO4);
    lt.send(ntla_pkg::RX_SIG0, 0);
    expect_out(ntla_pkg::ST_PDEACT, ntla_pkg::TX_SIG0, ntla_pkg::INFO0);
    uev(ntla_pkg::INFO0);
    expect_out(ntla_pkg::ST_DEACT, ntla_pkg::TX_SIG0, ntla_pkg::INFO0);
    $display("Test local wake done");
  endtask

  // User framing loss, loopback entry from user fault and both-ways sync, exits on SIG 4H and line framing loss
  task automatic t_loop();
    uev(ntla_pkg::INFO1);
    lt.send(ntla_pkg::RX_SIG2W, 0);
    lt.send(ntla_pkg::RX_SIG2_L2, 0);
    lt.send(ntla_pkg::RX_SIG4H, 0);
    expect_out(ntla_pkg::ST_FULL, ntla_pkg::TX_SIG5,
      ntla_pkg::INFO4);
    ulose();
    expect_out(ntla_pkg::ST_UFAULT, ntla_pkg::TX_SIG5,
      ntla_pkg::INFO2);
    lt.send(ntla_pkg::RX_SIG4_L2, 0);
    expect_out(ntla_pkg::ST_LBACT, ntla_pkg::TX_SIG5,
      ntla_pkg::INFO4);
    lt.lose();
    expect_out(ntla_pkg::ST_LFAULT, ntla_pkg::TX_SIG0,
      ntla_pkg::UZERO);
    lt.send(ntla_pkg::RX_SIG0, 0);
    uev(ntla_pkg::INFO0);
    uev(ntla_pkg::INFO1);
    lt.send(ntla_pkg::RX_SIG2W, 0);
    lt.send(ntla_pkg::RX_SIG2, 0);
    uev(ntla_pkg::INFO3);
    lt.send(ntla_pkg::RX_SIG4H_L2, 0);
    expect_out(ntla_pkg::ST_LBACT, ntla_pkg::TX_SIG5,
      ntla_pkg::INFO4);
    lt.send(ntla_pkg::RX_SIG0, 0);
    uev(ntla_pkg::INFO0);
    expect_out(ntla_pkg::ST_DEACT, ntla_pkg::TX_SIG0,
      ntla_pkg::INFO0);
    $display("Test loopback done");
  endtask

  // Main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    t_idle();
    t_remote();
    t_local();
    t_loop();
    conclude();
  end

  // Watchdog: the tests need about 150 cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    conclude();
  end
endmodule
